// ===== sirq_map.vh
// sirq_map.vh: constants for the serialized interrupt slave agent
// assumes: included by bare name from each design file of the agent
`ifndef SIRQ_MAP_VH
`define SIRQ_MAP_VH
// frame geometry
`define SIRQ_FRAME_CLKS 2'h3
`define SIRQ_PH_SAMPLE 2'h0
`define SIRQ_PH_RECOV 2'h1
`define SIRQ_PH_TURN 2'h2
// first data frame that carries a line, and the last one
`define SIRQ_FIRST_SLOT 5'h02
`define SIRQ_LAST_SLOT 5'h10
// frame that carries the shared management interrupt
`define SIRQ_MGMT_SLOT 5'h03
// stop pulse widths that select the next mode
`define SIRQ_STOP_QUIET 4'h2
`define SIRQ_STOP_CONT 4'h3
// a low pulse of this width or more is a start pulse
`define SIRQ_START_MIN 4'h4
// idle clocks after stop before an own start may go out
`define SIRQ_START_GAP 2'h2
// enable register bit positions
`define SIRQ_EN_FRAME_BIT 6
`define SIRQ_EN_PIN_BIT 7
// mode encoding
`define SIRQ_MODE_CONT 1'b0
`define SIRQ_MODE_QUIET 1'b1
`endif

// ===== sirq_sync.v
// sirq_sync.v: two-flop synchroniser for a bundle of levels
// assumes: inputs are asynchronous to mclk; output is used in mclk domain only
`timescale 1ns/10ps
`include "sirq_map.vh"
module sirq_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage read only by the second
  always @(posedge mclk) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // sirq_sync

// ===== sirq_pulse_meter.v
// sirq_pulse_meter.v: measures low pulses on the sampled serial line
// assumes: lineIn already synchronised to mclk, high when released
`timescale 1ns/10ps
`include "sirq_map.vh"
module sirq_pulse_meter #(
  parameter CW = 4
) (
  input wire mclk,
  input wire rst,
  input wire lineIn,
  output reg riseSeen,
  output reg [CW-1:0] lowWidth
);
  reg prev_q;
  reg [CW-1:0] cnt_q;

  // count low clocks, saturating; report width at the rising edge
  always @(posedge mclk) begin
    if (rst) begin
      prev_q <= 1'b1;
      cnt_q <= {CW{1'b0}};
      riseSeen <= 1'b0;
      lowWidth <= {CW{1'b0}};
    end else begin
      prev_q <= lineIn;
      riseSeen <= lineIn & ~prev_q;
      if (lineIn & ~prev_q)
        lowWidth <= cnt_q;
      if (lineIn)
        cnt_q <= {CW{1'b0}};
      else if (cnt_q != {CW{1'b1}})
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // sirq_pulse_meter

// ===== sirq_slave_agent.v
// sirq_slave_agent.v: slave agent for the one-wire serialized interrupt bus
// assumes: mclk is the bus clock; host drives start/stop pulses; line is
// wired-or with pullup, resolved outside from lineOut and lineOeN.
// Notes on behaviour
// - quiet idle mode: agent may pull line low one clock, then release.
// - never start a frame while a cycle is active.
// - line change requests a start unless current cycle can still carry it.
// - continuous mode: only host starts; agent stays passive.
// - mode changes only at a stop frame.
// - reset gives continuous mode; agent never requests the first start.
// - measure every stop pulse width to pick next mode.
// - count frames from start rising edge; three clocks each.
// - sample clock of own slot: drive low only if line level low.
// - recovery drives high only after own low; turnaround always released.
// - report low levels every cycle whoever started it.
// - frame N sample clock is 3N-1 clocks after start rise.
// - frame one unused; frames two to sixteen carry lines one to fifteen.
// - enable bit six gates management frame; bit seven gates its pin.
// - two clock stop selects quiet; start allowed second clock after rise; agent's own start waits to seventh clock.
// - three clock stop selects continuous; only host may then start.
// - accept idle clocks or an immediate start after stop turnaround.
// - all driving and sampling on rising mclk edges.
// - during bus reset line released; reset enters continuous mode.
`timescale 1ns/10ps
`include "sirq_map.vh"
module sirq_slave_agent #(
  parameter NLINES = 15
) (
  input wire mclk,
  input wire rst,
  input wire host_bus_reset_n,
  input wire [NLINES:1] irqLevel,
  input wire mgmt_interrupt_n,
  input wire [7:0] mgmtEnable2,
  input wire lineIn,
  output reg lineOut,
  output reg lineOeN,
  output reg mgmt_interrupt_out_n,
  output reg cycleActive,
  output reg quietMode
);
  // states of the agent
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOPWAIT = 2'h3;

  wire lineS;
  wire busRstN;
  wire [NLINES:1] irqS;
  wire mgmtS;
  wire riseSeen;
  wire [3:0] lowWidth;
  wire [NLINES+2:0] syncIn;
  wire [NLINES+2:0] syncOut;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [1:0] phase_q;
  reg [4:0] frame_q;
  reg drovelow_q;
  reg [NLINES:1] sent_q;
  reg [NLINES:1] lvl;
  reg pending_q;
  reg [1:0] gap_q;
  reg req_q;
  reg mode_q;

  // pins arrive from other domains: synchronise line, reset, levels
  assign syncIn = {lineIn, host_bus_reset_n, mgmt_interrupt_n, irqLevel};
  sirq_sync #(.WIDTH(NLINES + 3), .INIT({(NLINES + 3){1'b1}})) uSync (
    .mclk(mclk),
    .rst(rst),
    .din(syncIn),
    .dout(syncOut)
  );
  assign lineS = syncOut[NLINES+2];
  assign busRstN = syncOut[NLINES+1];
  assign mgmtS = syncOut[NLINES];
  assign irqS = syncOut[NLINES-1:0];

  sirq_pulse_meter #(.CW(4)) uMeter (
    .mclk(mclk),
    .rst(rst),
    .lineIn(lineS),
    .riseSeen(riseSeen),
    .lowWidth(lowWidth)
  );

  // frame number to line index; frame one carries nothing
  function [4:0] slotLine;
    input [4:0] frame;
    begin
      if (frame >= `SIRQ_FIRST_SLOT && frame <= `SIRQ_LAST_SLOT)
        slotLine = frame - 5'h01;
      else
        slotLine = 5'h00;
    end
  endfunction

  // level to report; frame three may carry the management interrupt
  always @* begin
    lvl = irqS;
    if (mgmtEnable2[`SIRQ_EN_FRAME_BIT] && NLINES >= 2)
      lvl[2] = irqS[2] & mgmtS; // shared use left to software
  end

  // state transitions
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (!lineS)
          st_d = ST_START; // host or other agent start, even right after stop
      end
      ST_START: begin
        if (riseSeen)
          st_d = ST_DATA; // frame count begins at start rise
      end
      ST_DATA: begin
        if (frame_q > `SIRQ_LAST_SLOT)
          st_d = ST_STOPWAIT; // own slots done; wait for host stop
      end
      ST_STOPWAIT: begin
        if (riseSeen && (lowWidth == `SIRQ_STOP_QUIET || lowWidth == `SIRQ_STOP_CONT))
          st_d = ST_IDLE; // host alone ends the cycle
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (rst || !busRstN) begin
      st_q <= ST_IDLE;
      phase_q <= `SIRQ_PH_SAMPLE;
      frame_q <= 5'h00;
      drovelow_q <= 1'b0;
      sent_q <= {NLINES{1'b1}};
      pending_q <= 1'b0;
      gap_q <= 2'h0;
      req_q <= 1'b0;
      mode_q <= `SIRQ_MODE_CONT; // reset selects continuous
      lineOut <= 1'b1;
      lineOeN <= 1'b1; // released through bus reset
      mgmt_interrupt_out_n <= 1'b1;
      cycleActive <= 1'b0;
      quietMode <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= 1'b0;
      lineOut <= 1'b1;
      lineOeN <= 1'b1; // default released; never high outside recovery
      // dedicated pin gated separately
      mgmt_interrupt_out_n <= ~(mgmtEnable2[`SIRQ_EN_PIN_BIT] & ~mgmtS);
      cycleActive <= (st_d != ST_IDLE);
      quietMode <= mode_q;
      // a change not yet deliverable in this cycle must raise a request
      pending_q <= (lvl != sent_q);
      // stop width picks next mode, only at stop frames
      if (st_q == ST_STOPWAIT && riseSeen) begin
        if (lowWidth == `SIRQ_STOP_QUIET)
          mode_q <= `SIRQ_MODE_QUIET;
        else if (lowWidth == `SIRQ_STOP_CONT)
          mode_q <= `SIRQ_MODE_CONT;
        gap_q <= 2'h0;
      end
      if (st_q == ST_START && riseSeen) begin
        // sync plus meter lag the rise three clocks: frame one is in turnaround
        phase_q <= `SIRQ_PH_TURN;
        frame_q <= 5'h01;
      end
      if (st_q == ST_DATA) begin
        // three clocks per frame, sample at 3N-1 after rise
        if (phase_q == `SIRQ_PH_TURN) begin
          phase_q <= `SIRQ_PH_SAMPLE;
          frame_q <= frame_q + 5'h01;
        end else begin
          phase_q <= phase_q + 2'h1;
        end
        if (phase_q == `SIRQ_PH_TURN && slotLine(frame_q + 5'h01) != 5'h00) begin
          // drive low in sample only for a low level, any initiator
          if (!lvl[slotLine(frame_q + 5'h01)]) begin
            lineOut <= 1'b0;
            lineOeN <= 1'b0;
            drovelow_q <= 1'b1;
          end else begin
            drovelow_q <= 1'b0;
          end
          sent_q[slotLine(frame_q + 5'h01)] <= lvl[slotLine(frame_q + 5'h01)];
        end
        // recovery high only after own low; turnaround released
        if (phase_q == `SIRQ_PH_SAMPLE && drovelow_q) begin
          lineOut <= 1'b1;
          lineOeN <= 1'b0;
          drovelow_q <= 1'b0;
        end
      end
      // idle gap after stop: start allowed after two idle clocks, seventh clock after rise
      if (st_q == ST_IDLE && gap_q != `SIRQ_START_GAP)
        gap_q <= gap_q + 2'h1;
      // quiet idle start request: one low clock, then release
      if (st_q == ST_IDLE && st_d == ST_IDLE && mode_q == `SIRQ_MODE_QUIET &&
          pending_q && gap_q == `SIRQ_START_GAP && !req_q) begin
        lineOut <= 1'b0;
        lineOeN <= 1'b0;
        req_q <= 1'b1;
        pending_q <= 1'b0;
        gap_q <= 2'h0; // no second pulse before our own start is seen
      end
    end
  end
endmodule // sirq_slave_agent

// ===== sirq_chk_assertions.sv
// checker for the slave agent port protocol
// assumes: bound to sirq_slave_agent, one clock domain
`timescale 1ns/10ps
module sirq_chk (
  input wire mclk,
  input wire rst,
  input wire mgmt_interrupt_n,
  input wire [7:0] mgmtEnable2,
  input wire lineOut,
  input wire lineOeN,
  input wire mgmt_interrupt_out_n,
  input wire cycleActive,
  input wire quietMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // low and high drive strobes on the line
  wire lo = !lineOeN && !lineOut;
  wire hi = !lineOeN && lineOut;
  a_reset_idle: assert property (disable iff (1'b0) rst |=> lineOeN && !quietMode)
    else $error("not idle after reset");
  a_low_once: assert property (lo |=> !lo)
    else $error("low drive too long");
  a_recov_high: assert property (lo && cycleActive |=> hi)
    else $error("no recovery high");
  a_turn_free: assert property (hi |=> lineOeN)
    else $error("turnaround driven");
  a_high_cause: assert property (hi |-> $past(lo))
    else $error("high without low");
  a_start_quiet: assert property (lo && !cycleActive |-> quietMode)
    else $error("start in continuous mode");
  a_mode_hold: assert property (cycleActive && $past(cycleActive) |-> $stable(quietMode))
    else $error("mode changed mid cycle");
  a_pin_low: assert property ((!mgmt_interrupt_n && mgmtEnable2[7]) [*5] |-> !mgmt_interrupt_out_n)
    else $error("pin not asserted");
  // main scenarios reached
  c_slot: cover property (lo && cycleActive);
  c_own_start: cover property (lo && !cycleActive);
  c_quiet: cover property ($rose(quietMode));
endmodule // sirq_chk

// ===== sirq_host_model.sv
// behavioural host controller for the serial line
// assumes: line resolved outside with pullup; hostOeN low while driving
`timescale 1ns/10ps
module sirq_host_model (
  input wire mclk,
  input wire rst,
  input wire lineWire,
  input wire go,
  input wire [3:0] startLen,
  input wire [3:0] stopLen,
  input wire [4:0] nFrames,
  output wire hostOut,
  output wire hostOeN,
  output reg busy,
  output reg [31:0] smp
);
  reg [7:0] t;
  wire [7:0] c = t - {4'h0, startLen};
  wire [7:0] s = 8'h3 * {3'h0, nFrames} + 8'h2;
  wire hiD = c == 8'h0 || c == s + stopLen;
  wire loD = c[7] || (c >= s && c < s + stopLen);
  // low start and stop pulses, one high clock, else released
  assign hostOut = hiD;
  assign hostOeN = !(busy && (hiD || loD));
  // counter and slot sampling on rising edges; no eoi path
  always @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0; // released in reset
      t <= 8'h0;
      smp <= 32'h0;
    end else if (!busy) begin
      busy <= go || !lineWire;
      t <= go ? 8'h0 : 8'h1;
      // keep last cycle's frames readable until the next start
      if (go || !lineWire)
        smp <= 32'h0;
    end else begin
      t <= t + 8'h1;
      if (!c[7] && c % 3 == 2) smp[(c + 1) / 3] <= lineWire;
      if (c == s + stopLen) busy <= 1'b0;
    end
  end
endmodule // sirq_host_model

// ===== sirq_slave_agent_tb.sv
// bench for the slave agent against a behavioural host
// assumes: design, host model and checker compiled first
`timescale 1ns/10ps
module sirq_slave_agent_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg busRstN = 1'b1;
  reg [15:1] irq = 15'h7FFF;
  reg mgmtN = 1'b1;
  reg [7:0] en = 8'h00;
  reg go = 1'b0;
  reg [3:0] sl = 4'h4;
  reg [3:0] pl = 4'h3;
  reg [4:0] nf = 5'h11;
  reg [32:0] rows [0:3];
  wire lineOut, lineOeN, pinN, act, quiet, hOut, hOeN, busy;
  wire [31:0] smp;
  // wired line, pullup when nobody drives
  wire line = !lineOeN ? lineOut : (!hOeN ? hOut : 1'b1);
  integer num_errors = 0;
  integer samples_checked = 0;
  integer i;
  always #5 mclk = ~mclk;
  sirq_slave_agent i_dut (.mclk(mclk), .rst(rst), .host_bus_reset_n(busRstN),
    .irqLevel(irq), .mgmt_interrupt_n(mgmtN), .mgmtEnable2(en), .lineIn(line),
    .lineOut(lineOut), .lineOeN(lineOeN), .mgmt_interrupt_out_n(pinN),
    .cycleActive(act), .quietMode(quiet));
  sirq_host_model i_host (.mclk(mclk), .rst(rst), .lineWire(line), .go(go),
    .startLen(sl), .stopLen(pl), .nFrames(nf), .hostOut(hOut), .hostOeN(hOeN),
    .busy(busy), .smp(smp));
  // compare and count
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one host-collected cycle; a stalled host shows as stale frames
  task run(input h, input [3:0] p);
    integer k;
    begin
      @(posedge mclk);
      pl <= p;
      go <= h;
      @(posedge mclk);
      go <= 1'b0;
      k = 0;
      while (!busy && k < 40) begin
        @(negedge mclk);
        k = k + 1;
      end
      while (busy && k < 200) begin
        @(negedge mclk);
        k = k + 1;
      end
      repeat (4) @(negedge mclk);
      chk("frames", {1'b1, irq[15:3], irq[2] & (mgmtN | !en[6]), irq[1], 1'b1}, smp[17:1]);
      chk("mode", p == 4'h2, quiet);
    end
  endtask
  // verdict and end of run
  task summarize;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // rows: frames, start width, enables, mgmt level, line levels
  initial begin
    rows[0] = {5'h11, 4'h4, 8'h00, 1'b1, 15'h7FFF};
    rows[1] = {5'h11, 4'h8, 8'h80, 1'b0, 15'h5555};
    rows[2] = {5'h15, 4'h6, 8'hC0, 1'b0, 15'h2AAA};
    rows[3] = {5'h12, 4'h5, 8'h40, 1'b1, 15'h3FFE};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge mclk);
      {nf, sl, en, mgmtN, irq} <= rows[i];
      repeat (6) @(negedge mclk);
      chk("pin", !(en[7] && !mgmtN), pinN);
      run(1'b1, 4'h3);
    end
    run(1'b1, 4'h2);
    @(posedge mclk);
    irq[5] <= 1'b0;
    run(1'b0, 4'h3);
    @(posedge mclk);
    irq[5] <= 1'b1;
    repeat (30) @(negedge mclk);
    chk("no start", 0, busy);
    run(1'b1, 4'h2);
    @(posedge mclk);
    busRstN <= 1'b0;
    repeat (4) @(posedge mclk);
    busRstN <= 1'b1;
    @(negedge mclk);
    chk("bus reset", 2'h1, {quiet, lineOeN});
    repeat (30) @(negedge mclk);
    chk("no first start", 0, busy);
    summarize;
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule // sirq_slave_agent_tb
bind sirq_slave_agent sirq_chk i_chk (.mclk(mclk), .rst(rst),
  .mgmt_interrupt_n(mgmt_interrupt_n), .mgmtEnable2(mgmtEnable2), .lineOut(lineOut),
  .lineOeN(lineOeN), .mgmt_interrupt_out_n(mgmt_interrupt_out_n),
  .cycleActive(cycleActive), .quietMode(quietMode));
